// File: hw/lpcd_defines.svh
// Command encodings, widths and timing counts for the command and power-state decoder
`ifndef LPCD_DEFINES_SVH
`define LPCD_DEFINES_SVH
`define LPCD_CA_W 10
`define LPCD_BANK_W 3
`define LPCD_COL_W 12
`define LPCD_ROW_W 15
// Rising-edge opcode fields on cmd_addr_bus[3:0]
`define LPCD_OP_MRW 4'h0
`define LPCD_OP_MRR 4'h8
`define LPCD_OP_REFPB 4'h4
`define LPCD_OP_REFAB 4'hC
`define LPCD_OP3_SELF_REFRESH_STATE 3'h4
`define LPCD_OP3_DEEP 3'h3
`define LPCD_OP3_NOP 3'h7
`define LPCD_OP4_PRE 4'hB
`define LPCD_OP4_BST 4'h3
`define LPCD_OP3_WR 3'h1
`define LPCD_OP3_RD 3'h5
`define LPCD_OP2_ACT 2'h2
// Timing figures in ns and derived cycle counts at 100 ns clock
`define LPCD_CLK_NS 100
`define LPCD_XP_NS 7500
`define LPCD_XSR_NS 140000
`define LPCD_INIT5_NS 10000000
`define LPCD_XP_CYC ((`LPCD_XP_NS + `LPCD_CLK_NS - 1) / `LPCD_CLK_NS)
`define LPCD_XSR_CYC ((`LPCD_XSR_NS + `LPCD_CLK_NS - 1) / `LPCD_CLK_NS)
`define LPCD_INIT5_CYC ((`LPCD_INIT5_NS + `LPCD_CLK_NS - 1) / `LPCD_CLK_NS)
`define LPCD_BURST_CYC 4
`define LPCD_PRE_CYC 3
`define LPCD_TOGGLES 2
`endif

// File: hw/lpcd_pkg.sv
// Types shared by both ends of the command link
package lpcd_pkg;
    typedef enum logic [3:0] {
        LPCD_POWER_ON = 4'h0,
        LPCD_RESETTING = 4'h1,
        LPCD_IDLE = 4'h2,
        LPCD_ACTIVE = 4'h3,
        LPCD_PD_ACTIVE = 4'h4,
        LPCD_PD_IDLE = 4'h5,
        LPCD_PD_RESET = 4'h6,
        LPCD_SELF_REFRESH = 4'h7,
        LPCD_DEEP_SLEEP = 4'h8
    } lpcd_state_t;
    typedef enum logic [3:0] {
        LPCD_C_NOP = 4'h0,
        LPCD_C_MRW = 4'h1,
        LPCD_C_MRR = 4'h2,
        LPCD_C_REFPB = 4'h3,
        LPCD_C_REFAB = 4'h4,
        LPCD_C_ACT = 4'h5,
        LPCD_C_WR = 4'h6,
        LPCD_C_RD = 4'h7,
        LPCD_C_PRE = 4'h8,
        LPCD_C_BST = 4'h9,
        LPCD_C_SELF_REFRESH_STATE = 4'hA,
        LPCD_C_DEEP = 4'hB,
        LPCD_C_PDE = 4'hC,
        LPCD_C_EXIT = 4'hD
    } lpcd_cmd_t;
endpackage : lpcd_pkg

// File: hw/lpcd_link_if.sv
// Command/address link between memory controller and memory die
`timescale 1ns/100ps
interface lpcd_link_if;
    logic clk_en;
    logic chip_sel_b;
    logic [9:0] cmd_addr_bus;
    logic [9:0] cmd_addr_bus_fall;
    modport ctrl (output clk_en, output chip_sel_b, output cmd_addr_bus, output cmd_addr_bus_fall);
    modport mem (input clk_en, input chip_sel_b, input cmd_addr_bus, input cmd_addr_bus_fall);
endinterface : lpcd_link_if

// File: hw/lpcd_ctrl.sv
// Controller end: drives power-state requests and commands onto the link
`timescale 1ns/100ps
`include "lpcd_defines.svh"
module lpcd_ctrl import lpcd_pkg::*; #(
    parameter int XP_CYC = `LPCD_XP_CYC,
    parameter int XSR_CYC = `LPCD_XSR_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // User request
    input wire logic req_valid,
    input wire lpcd_cmd_t req_cmd,
    input wire logic [9:0] req_rise,
    input wire logic [9:0] req_fall,
    output logic req_ready,
    // Link
    lpcd_link_if.ctrl link
);
    typedef enum logic [1:0] {
        LPCD_K_RUN = 2'h0,
        LPCD_K_LOW = 2'h1,
        LPCD_K_TOG = 2'h2,
        LPCD_K_WAIT = 2'h3
    } lpcd_kstate_t;
    lpcd_kstate_t kst;
    logic [17:0] cnt;
    logic was_self_refresh_state;
    logic low_deep;
    logic accept;

    // any request is taken while running; only an exit request is taken while enable is low
    assign req_ready = (kst == LPCD_K_RUN) || (kst == LPCD_K_LOW && req_cmd == LPCD_C_EXIT);
    assign accept = req_valid && req_ready;

    // Power sequencing of clock enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            kst <= LPCD_K_RUN;
            cnt <= 18'h00000;
            was_self_refresh_state <= 1'b0;
            low_deep <= 1'b0;
        end else if (ce) begin
            unique case (kst)
                LPCD_K_RUN: begin
                    if (accept && (req_cmd == LPCD_C_PDE || req_cmd == LPCD_C_SELF_REFRESH_STATE
                                   || req_cmd == LPCD_C_DEEP)) begin
                        kst <= LPCD_K_LOW;
                        was_self_refresh_state <= (req_cmd == LPCD_C_SELF_REFRESH_STATE);
                        low_deep <= (req_cmd == LPCD_C_DEEP);
                    end
                end
                LPCD_K_LOW: begin
                    if (accept) begin
                        kst <= low_deep ? LPCD_K_RUN : LPCD_K_TOG;
                        cnt <= 18'h00000;
                    end
                end
                // two clock toggles before the exit wait counts
                LPCD_K_TOG: begin
                    cnt <= cnt + 18'h00001;
                    if (cnt == 18'(`LPCD_TOGGLES - 1)) begin
                        kst <= LPCD_K_WAIT;
                        cnt <= 18'h00000;
                    end
                end
                // hold no-operations through the exit wait
                LPCD_K_WAIT: begin
                    cnt <= cnt + 18'h00001;
                    if (cnt == (was_self_refresh_state ? 18'(XSR_CYC - 1) : 18'(XP_CYC - 1))) begin
                        kst <= LPCD_K_RUN;
                    end
                end
            endcase
        end
    end

    // Link drive; two bit sets per cycle, idle cycles are chip select high
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            link.clk_en <= 1'b1;
            link.chip_sel_b <= 1'b1;
            link.cmd_addr_bus <= 10'h3FF;
            link.cmd_addr_bus_fall <= 10'h3FF;
        end else if (ce) begin
            link.chip_sel_b <= 1'b1;
            link.cmd_addr_bus <= 10'h3FF;
            link.cmd_addr_bus_fall <= 10'h3FF;
            if (accept) begin
                // deep sleep exit with chip select high starts over
                if (req_cmd == LPCD_C_EXIT) begin
                    link.clk_en <= 1'b1;
                end else begin
                    link.clk_en <= !(req_cmd == LPCD_C_PDE || req_cmd == LPCD_C_SELF_REFRESH_STATE
                                     || req_cmd == LPCD_C_DEEP);
                    link.chip_sel_b <= (req_cmd == LPCD_C_NOP || req_cmd == LPCD_C_PDE);
                    link.cmd_addr_bus <= req_rise;
                    link.cmd_addr_bus_fall <= req_fall;
                end
            end
        end
    end
endmodule : lpcd_ctrl

// File: hw/lpcd_mem.sv
// Memory end: command decode and power-state tracking
`timescale 1ns/100ps
`include "lpcd_defines.svh"
// How it works
// - Commands decoded from rising-edge select, opcode, enable
// - Bank commands act on addressed bank only, except precharge-all
// - Auto-close flag precharges bank after access
// - Self-refresh and deep-sleep exit seen asynchronously
// - Bus carries rising and falling bit sets
// - Enable compared with previous rising sample
// - Per-bank refresh only with eight banks
// - Lowest column bit forced to zero
// - Controller sends no-ops through powerdown exit wait
// - Controller sends no-ops through self-refresh exit wait
// - Controller gives two toggles before exit wait
// - Resetting powerdown exit goes idle after init wait
// - Deep sleep exit lands in power-on state
// - Controller sends only legal combinations
// - Steady high enable uses normal decoder
// - No-op is select high or opcode 111
// - No-op lets ongoing bursts finish
module lpcd_mem import lpcd_pkg::*; #(
    parameter int NUM_BANKS = 8,
    parameter int INIT5_CYC = `LPCD_INIT5_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Link
    lpcd_link_if.mem link,
    // Decoded outputs
    output lpcd_state_t state,
    output lpcd_cmd_t last_cmd,
    output logic cmd_strobe,
    output logic [2:0] cmd_bank,
    output logic [11:0] cmd_col,
    output logic [14:0] cmd_row,
    output logic [7:0] bank_open,
    output logic burst_busy,
    output logic illegal
);
    logic cke_prev;
    logic [24:0] init_cnt;
    logic init_done;
    logic [2:0] bcnt;
    logic [2:0] burst_bank;
    logic burst_ap;
    logic [1:0] pcnt;
    logic wake_async;
    lpcd_cmd_t dec;

    // decode from select and opcode bits on the rising sample
    function automatic lpcd_cmd_t decode(input logic csb, input logic [3:0] op, input int nb);
        lpcd_cmd_t c;
        c = LPCD_C_NOP;
        if (csb || op[2:0] == `LPCD_OP3_NOP) c = LPCD_C_NOP;
        else if (op == `LPCD_OP_MRW) c = LPCD_C_MRW;
        else if (op == `LPCD_OP_MRR) c = LPCD_C_MRR;
        // per-bank refresh only with eight banks
        else if (op == `LPCD_OP_REFPB) c = (nb == 8) ? LPCD_C_REFPB : LPCD_C_NOP;
        else if (op == `LPCD_OP_REFAB) c = LPCD_C_REFAB;
        else if (op[1:0] == `LPCD_OP2_ACT) c = LPCD_C_ACT;
        else if (op[2:0] == `LPCD_OP3_WR) c = LPCD_C_WR;
        else if (op[2:0] == `LPCD_OP3_RD) c = LPCD_C_RD;
        else if (op == `LPCD_OP4_PRE) c = LPCD_C_PRE;
        else if (op == `LPCD_OP4_BST) c = LPCD_C_BST;
        return c;
    endfunction : decode

    // bank select rides on the top three rising-edge bits
    function automatic logic [2:0] bank_of(input logic [9:0] rise);
        return rise[9:7];
    endfunction : bank_of

    assign dec = decode(link.chip_sel_b, link.cmd_addr_bus[3:0], NUM_BANKS);
    // wake from self refresh or deep sleep is a plain level, no register
    // The strobe is masked on wake so the exit edge is never taken as a command
    assign wake_async = link.clk_en
        && (state == LPCD_SELF_REFRESH || state == LPCD_DEEP_SLEEP);
    assign init_done = (init_cnt == 25'(INIT5_CYC));

    // remember enable from the previous rising edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) cke_prev <= 1'b1;
        else if (ce) cke_prev <= link.clk_en;
    end

    // Final initialisation wait counter while resetting
    // Saturates at the limit so a late power-down exit still sees it expired
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) init_cnt <= 25'h0000000;
        else if (ce) begin
            if (state == LPCD_POWER_ON) init_cnt <= 25'h0000000;
            else if (!init_done) init_cnt <= init_cnt + 25'h0000001;
        end
    end

    // Power-state machine
    // Exit, entry and steady decode are picked by the enable pair alone
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= LPCD_POWER_ON;
            illegal <= 1'b0;
        end else if (ce) begin
            if (!cke_prev) begin
                if (link.clk_en) begin
                    unique case (state)
                        LPCD_PD_ACTIVE: state <= LPCD_ACTIVE;
                        LPCD_PD_IDLE: state <= LPCD_IDLE;
                        // idle only once the init wait expired
                        LPCD_PD_RESET: state <= init_done ? LPCD_IDLE : LPCD_RESETTING;
                        LPCD_DEEP_SLEEP: state <= LPCD_POWER_ON;
                        LPCD_SELF_REFRESH: state <= LPCD_IDLE;
                        default: illegal <= 1'b1;
                    endcase
                end
            end else if (!link.clk_en) begin
                // select high enters the matching power-down
                if (link.chip_sel_b) begin
                    if (state == LPCD_RESETTING) state <= LPCD_PD_RESET;
                    else if (state == LPCD_ACTIVE || burst_busy) state <= LPCD_PD_ACTIVE;
                    else state <= LPCD_PD_IDLE;
                // from idle, command picks self refresh or deep sleep
                end else if (state == LPCD_IDLE && bank_open == 8'h00) begin
                    if (link.cmd_addr_bus[2:0] == `LPCD_OP3_SELF_REFRESH_STATE) state <= LPCD_SELF_REFRESH;
                    else if (link.cmd_addr_bus[2:0] == `LPCD_OP3_DEEP) state <= LPCD_DEEP_SLEEP;
                    else illegal <= 1'b1;
                end else illegal <= 1'b1;
            // steady enable follows the normal decoder
            end else begin
                unique case (dec)
                    LPCD_C_MRW: if (state == LPCD_POWER_ON) state <= LPCD_RESETTING;
                    LPCD_C_ACT: state <= LPCD_ACTIVE;
                    default: begin
                        if (state == LPCD_RESETTING && init_done) state <= LPCD_IDLE;
                        else if (state == LPCD_ACTIVE && bank_open == 8'h00
                                 && !burst_busy) state <= LPCD_IDLE;
                    end
                endcase
            end
        end
    end

    // Command capture; rising and falling halves combine, column bit zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            last_cmd <= LPCD_C_NOP;
            cmd_strobe <= 1'b0;
            cmd_bank <= 3'h0;
            cmd_col <= 12'h000;
            cmd_row <= 15'h0000;
        end else if (ce) begin
            cmd_strobe <= cke_prev && link.clk_en && !wake_async && dec != LPCD_C_NOP;
            if (cke_prev && link.clk_en) begin
                last_cmd <= dec;
                // bank address from the rising half
                cmd_bank <= bank_of(link.cmd_addr_bus);
                cmd_col <= {link.cmd_addr_bus_fall[9:1], link.cmd_addr_bus[6:5], 1'b0};
                cmd_row <= {link.cmd_addr_bus_fall[9:8], link.cmd_addr_bus[6:2],
                            link.cmd_addr_bus_fall[7:0]};
            end
        end
    end

    // Bank open map and burst tracking
    // A command in the cycle a countdown ends overrides it, being assigned last
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bank_open <= 8'h00;
            bcnt <= 3'h0;
            burst_bank <= 3'h0;
            burst_ap <= 1'b0;
            pcnt <= 2'h0;
        end else if (ce) begin
            // no-op leaves a running burst counting down
            if (bcnt != 3'h0) bcnt <= bcnt - 3'h1;
            if (pcnt != 2'h0) pcnt <= pcnt - 2'h1;
            // auto-close precharges the bank after the burst ends
            if (bcnt == 3'h1 && burst_ap) pcnt <= 2'(`LPCD_PRE_CYC);
            if (pcnt == 2'h1) bank_open[burst_bank] <= 1'b0;
            if (cke_prev && link.clk_en) begin
                unique case (dec)
                    LPCD_C_ACT: bank_open[bank_of(link.cmd_addr_bus)] <= 1'b1;
                    LPCD_C_PRE: begin
                        if (link.cmd_addr_bus[4]) bank_open <= 8'h00;
                        else bank_open[bank_of(link.cmd_addr_bus)] <= 1'b0;
                    end
                    LPCD_C_RD, LPCD_C_WR: begin
                        bcnt <= 3'(`LPCD_BURST_CYC);
                        burst_bank <= bank_of(link.cmd_addr_bus);
                        // flag rides on the falling half bit 0
                        burst_ap <= link.cmd_addr_bus_fall[0];
                    end
                    LPCD_C_BST: begin
                        bcnt <= 3'h0;
                        burst_ap <= 1'b0;
                    end
                    default: ;
                endcase
            end
        end
    end
    assign burst_busy = (bcnt != 3'h0);
endmodule : lpcd_mem

// File: verification/lpcd_props.sv
// Link and decoder assertions for the controller and memory ends
`timescale 1ns/100ps
module lpcd_props import lpcd_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Link
    input wire logic clk_en,
    input wire logic chip_sel_b,
    input wire logic [9:0] cmd_addr_bus,
    input wire logic [9:0] cmd_addr_bus_fall,
    // Memory decode
    input wire lpcd_state_t state,
    input wire lpcd_cmd_t last_cmd,
    input wire logic cmd_strobe,
    input wire logic [2:0] cmd_bank,
    input wire logic [11:0] cmd_col
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Selected non-idle opcode under steady enable gives a strobe
    a_cmd_gives_strobe: assert property (
        (!chip_sel_b && clk_en && $past(clk_en) && cmd_addr_bus[2:0] != 3'h7) |=> cmd_strobe)
        else $error("command with steady enable gave no strobe");
    a_nop_no_strobe: assert property (
        (chip_sel_b && clk_en && $past(clk_en)) |=> !cmd_strobe)
        else $error("deselected cycle gave a strobe");
    a_col_from_both: assert property (
        (cmd_strobe && last_cmd inside {LPCD_C_RD, LPCD_C_WR}) |->
        cmd_col == {$past(cmd_addr_bus_fall[9:1]), $past(cmd_addr_bus[6:5]), 1'b0})
        else $error("column not built from both edge sets");
    a_bank_from_bus: assert property (
        (cmd_strobe && last_cmd inside {LPCD_C_RD, LPCD_C_WR, LPCD_C_ACT, LPCD_C_PRE}) |->
        cmd_bank == $past(cmd_addr_bus[9:7]))
        else $error("bank does not follow bus");
    a_pd_entry_kind: assert property (
        ($fell(clk_en) && chip_sel_b && state inside {LPCD_IDLE, LPCD_ACTIVE, LPCD_RESETTING})
        |=> state == ($past(state) == LPCD_IDLE ? LPCD_PD_IDLE :
                      $past(state) == LPCD_ACTIVE ? LPCD_PD_ACTIVE : LPCD_PD_RESET))
        else $error("wrong powerdown entry");
    a_low_state_hold: assert property (
        (!clk_en && state inside {LPCD_PD_ACTIVE, LPCD_PD_IDLE, LPCD_PD_RESET,
                                  LPCD_SELF_REFRESH, LPCD_DEEP_SLEEP}) |=> $stable(state))
        else $error("low power state left while enable low");
    a_sleep_entry: assert property (
        ($fell(clk_en) && !chip_sel_b && state == LPCD_IDLE &&
         cmd_addr_bus[2:0] inside {3'h4, 3'h3}) |=>
        state == ($past(cmd_addr_bus[2:0]) == 3'h4 ? LPCD_SELF_REFRESH : LPCD_DEEP_SLEEP))
        else $error("wrong sleep entry");
    a_pd_exit_back: assert property (
        ($rose(clk_en) && state inside {LPCD_PD_IDLE, LPCD_PD_ACTIVE}) |=>
        state == ($past(state) == LPCD_PD_IDLE ? LPCD_IDLE : LPCD_ACTIVE))
        else $error("powerdown exit went wrong");
    a_self_refresh_state_exit_idle: assert property (
        ($rose(clk_en) && state == LPCD_SELF_REFRESH) |=> state == LPCD_IDLE)
        else $error("self refresh exit not idle");
    a_deep_exit_on: assert property (
        ($rose(clk_en) && state == LPCD_DEEP_SLEEP) |=> state == LPCD_POWER_ON)
        else $error("deep sleep exit not power-on");
    // Toggles plus exit wait of 4 cycles in the bench give six quiet edges
    a_exit_quiet: assert property (
        ($rose(clk_en) && state != LPCD_DEEP_SLEEP) |-> chip_sel_b [*6])
        else $error("command sent inside exit wait");

    // Main scenarios reached
    c_self_refresh_state: cover property (state == LPCD_SELF_REFRESH);
    c_deep: cover property (state == LPCD_DEEP_SLEEP);
    c_read: cover property (cmd_strobe && last_cmd == LPCD_C_RD);
endmodule : lpcd_props

// File: verification/ddr_command_power_state_decode_bench.sv
// Bench joining controller and memory ends through the command link
`timescale 1ns/100ps
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("unexpected at %0t: value %0h expected %0h", $time, got, exp); \
        end \
    end
module ddr_command_power_state_decode_bench import lpcd_pkg::*; ;
    logic clk;
    logic rst_b;
    logic ce;
    logic req_valid;
    lpcd_cmd_t req_cmd;
    logic [9:0] req_rise;
    logic [9:0] req_fall;
    logic req_ready;
    lpcd_state_t state;
    lpcd_cmd_t last_cmd;
    logic cmd_strobe;
    logic [2:0] cmd_bank;
    logic [11:0] cmd_col;
    logic [14:0] cmd_row;
    logic [7:0] bank_open;
    logic burst_busy;
    logic illegal;
    int fails;
    int checks_done;
    lpcd_cmd_t idle_cmd [3] = '{LPCD_C_MRR, LPCD_C_REFPB, LPCD_C_REFAB};
    logic [9:0] idle_bits [3] = '{10'h008, 10'h004, 10'h00C};

    // Ends and checker around one link
    lpcd_link_if link ();
    lpcd_ctrl #(.XP_CYC(4), .XSR_CYC(4)) i_lpcd_ctrl (.clk(clk), .rst_b(rst_b), .ce(ce),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_rise(req_rise), .req_fall(req_fall),
        .req_ready(req_ready), .link(link.ctrl));
    lpcd_mem #(.NUM_BANKS(8), .INIT5_CYC(40)) i_lpcd_mem (.clk(clk), .rst_b(rst_b), .ce(ce),
        .link(link.mem), .state(state), .last_cmd(last_cmd), .cmd_strobe(cmd_strobe),
        .cmd_bank(cmd_bank), .cmd_col(cmd_col), .cmd_row(cmd_row), .bank_open(bank_open),
        .burst_busy(burst_busy), .illegal(illegal));
    lpcd_props i_props (.clk(clk), .rst_b(rst_b), .clk_en(link.clk_en),
        .chip_sel_b(link.chip_sel_b), .cmd_addr_bus(link.cmd_addr_bus),
        .cmd_addr_bus_fall(link.cmd_addr_bus_fall), .state(state), .last_cmd(last_cmd),
        .cmd_strobe(cmd_strobe), .cmd_bank(cmd_bank), .cmd_col(cmd_col));

    // 10 MHz clock
    initial clk = 1'b0;
    always #50 clk = ~clk;

    // Verdict and stop
    task automatic end_sim();
        if (fails == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    // One request, held until taken, then wait until memory outputs land
    task automatic go(input lpcd_cmd_t c, input logic [9:0] r, input logic [9:0] f);
        int n;
        n = 0;
        @(negedge clk);
        req_valid = 1'b1;
        req_cmd = c;
        req_rise = r;
        req_fall = f;
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n >= 100) begin
            fails++;
            $display("unexpected at %0t: request never taken", $time);
            end_sim();
        end
        @(negedge clk);
        req_valid = 1'b0;
        @(negedge clk);
    endtask : go

    // Bounded wait for a memory state
    task automatic wait_state(input lpcd_state_t s);
        int n;
        n = 0;
        while (state !== s && n < 200) begin
            @(negedge clk);
            n++;
        end
        `CHK(state, s)
    endtask : wait_state

    // Main sequence
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        req_valid = 1'b0;
        req_cmd = LPCD_C_NOP;
        req_rise = 10'h3FF;
        req_fall = 10'h3FF;
        fails = 0;
        checks_done = 0;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        `CHK(state, LPCD_POWER_ON)
        go(LPCD_C_MRW, 10'h000, 10'h000);
        `CHK(state, LPCD_RESETTING)
        `CHK(cmd_strobe, 1'b1)
        go(LPCD_C_PDE, 10'h3FF, 10'h3FF);
        `CHK(state, LPCD_PD_RESET)
        go(LPCD_C_EXIT, 10'h3FF, 10'h3FF);
        `CHK(state, LPCD_RESETTING)
        wait_state(LPCD_IDLE);
        for (int i = 0; i < 3; i++) begin
            go(idle_cmd[i], idle_bits[i], 10'h000);
            `CHK(last_cmd, idle_cmd[i])
        end
        go(LPCD_C_ACT, 10'h2CA, 10'h2A5);
        `CHK(cmd_bank, 3'h5)
        `CHK(cmd_row, 15'h52A5)
        `CHK(bank_open, 8'h20)
        go(LPCD_C_RD, 10'h2E5, 10'h2AA);
        `CHK(cmd_col, 12'hAAE)
        `CHK(burst_busy, 1'b1)
        @(negedge clk);
        ce = 1'b0;
        repeat (4) @(negedge clk);
        `CHK(burst_busy, 1'b1)
        ce = 1'b1;
        go(LPCD_C_RD, 10'h2E5, 10'h2AA);
        go(LPCD_C_BST, 10'h003, 10'h000);
        `CHK(burst_busy, 1'b0)
        repeat (8) @(negedge clk);
        `CHK(bank_open, 8'h20)
        go(LPCD_C_WR, 10'h281, 10'h001);
        `CHK(last_cmd, LPCD_C_WR)
        repeat (8) @(negedge clk);
        `CHK(bank_open, 8'h00)
        wait_state(LPCD_IDLE);
        go(LPCD_C_PDE, 10'h3FF, 10'h3FF);
        `CHK(state, LPCD_PD_IDLE)
        repeat (3) @(negedge clk);
        `CHK(state, LPCD_PD_IDLE)
        go(LPCD_C_EXIT, 10'h3FF, 10'h3FF);
        `CHK(state, LPCD_IDLE)
        go(LPCD_C_ACT, 10'h102, 10'h000);
        go(LPCD_C_PDE, 10'h3FF, 10'h3FF);
        `CHK(state, LPCD_PD_ACTIVE)
        go(LPCD_C_EXIT, 10'h3FF, 10'h3FF);
        `CHK(state, LPCD_ACTIVE)
        go(LPCD_C_ACT, 10'h282, 10'h000);
        `CHK(bank_open, 8'h24)
        go(LPCD_C_PRE, 10'h10B, 10'h000);
        `CHK(bank_open, 8'h20)
        go(LPCD_C_PRE, 10'h11B, 10'h000);
        `CHK(bank_open, 8'h00)
        wait_state(LPCD_IDLE);
        go(LPCD_C_SELF_REFRESH_STATE, 10'h004, 10'h000);
        `CHK(state, LPCD_SELF_REFRESH)
        go(LPCD_C_EXIT, 10'h3FF, 10'h3FF);
        `CHK(state, LPCD_IDLE)
        go(LPCD_C_DEEP, 10'h003, 10'h000);
        `CHK(state, LPCD_DEEP_SLEEP)
        go(LPCD_C_EXIT, 10'h3FF, 10'h3FF);
        `CHK(state, LPCD_POWER_ON)
        `CHK(illegal, 1'b0)
        end_sim();
    end
endmodule : ddr_command_power_state_decode_bench
